//--- tb/dpt_pin_src.sv
// Far-side model of the timer pin: an external level source
`timescale 1ns/1ps
`default_nettype none
module dpt_pin_src (
  // Source level and device drive
  input  wire logic level_i,
  input  wire logic pin_o_i,
  input  wire logic oe_n_i,
  // Wire seen by the device
  output logic      pin_o
);
  // ==========================================================================
  // Wire level
  // The source backs off while the device drives, so the wire shows the drive
  assign pin_o = oe_n_i ? level_i : pin_o_i;
endmodule
`default_nettype wire

//--- tb/dpt_timer_tb.sv
// Self-checking bench for the dual prescaled down timer
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_tb;
  import dpt_pkg::*;
  localparam logic [11:0] PSC0 = {2'b00, IDX_PSC[0], 2'b00};
  localparam logic [11:0] CNT0 = {2'b00, IDX_CNT[0], 2'b00};
  localparam logic [11:0] CTL0 = {2'b00, IDX_CTL[0], 2'b00};
  localparam logic [11:0] CNT1 = {2'b00, IDX_CNT[1], 2'b00};
  localparam logic [11:0] CTL1 = {2'b00, IDX_CTL[1], 2'b00};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, er, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        pin_level, pin_wire, pin_o, pin_oe_n, wake;
  logic [1:0]  irq;
  int          err_total = 0;
  int          n_checks = 0;
  int          n;

  always #10 clk = ~clk;

  dpt_timer dut_u (.clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tmr_pin_i(pin_wire), .tmr_pin_o(pin_o),
    .tmr_pin_oe_n_o(pin_oe_n), .zero_irq_o(irq), .wake_o(wake));
  dpt_pin_src pin_u (.level_i(pin_level), .pin_o_i(pin_o), .oe_n_i(pin_oe_n),
    .pin_o(pin_wire));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Two tap-select rises of bit t-1 from 7Fh take 2^(t+1) divided ticks
  function automatic int exp_cyc(input int t);
    return 24 << t;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // Setup cycle, then access phase held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, msg);
  endtask

  task automatic pulse(input int cnt);
    repeat (cnt) begin
      pin_level <= 1'b1;
      repeat (6) @(posedge clk);
      pin_level <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog, well beyond the roughly 6700 cycles the tests take
  initial begin
    #(20 * 40000);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude;
  end

  // ==========================================================================
  // Tests
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pin_level = 1'b0;
    seed = 32'h3AED766B;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      rdc({2'b00, IDX_PSC[i], 2'b00}, {25'h0, PSC_RST}, "psc reset");
      rdc({2'b00, IDX_CNT[i], 2'b00}, {24'h0, CNT_RST}, "cnt reset");
      rdc({2'b00, IDX_CTL[i], 2'b00}, {24'h0, CTL_RST}, "ctl reset");
    end
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk({31'h0, er}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset and map done");

    seed = xs(seed);
    wr(CNT1, {24'h0, seed[7:0] | 8'h01});
    rdc(CNT1, {24'h0, seed[7:0] | 8'h01}, "cnt load");
    wr(CTL1, 32'h40);
    wr(CNT1, 32'h00);
    chk({30'h0, irq}, 32'h2, "irq on zero write");
    chk({31'h0, wake}, 32'h1, "wake");
    rdc(CTL1, 32'hC0, "flag on zero write");
    wr(CTL1, 32'h40);
    chk({30'h0, irq}, 32'h0, "irq cleared");
    wr(CTL1, 32'hC0);
    chk({30'h0, irq}, 32'h2, "flag by bit seven");
    wr(CTL1, 32'h00);
    repeat (60) @(posedge clk);
    rdc(CNT1, 32'h00, "stopped count");
    $display("test flag and irq done");

    for (int t = 0; t < 8; t++) begin
      wr(CNT1, 32'h02);
      apb(1'b1, CTL1, 32'h58 | t);
      n = 0;
      while (irq[1] !== 1'b1 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      ok = (n >= exp_cyc(t) - 14) && (n <= exp_cyc(t) + 6);
      chk({31'h0, ok}, 32'h1, "tap span");
      wr(CTL1, 32'h00);
    end
    $display("test taps done");

    wr(CTL0, 32'h18);
    wr(CNT0, 32'h40);
    repeat (60) @(posedge clk);
    rdc(CNT0, 32'h40, "gate low");
    pin_level <= 1'b1;
    repeat (120) @(posedge clk);
    pin_level <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b0, CNT0, 32'h0000_0000);
    ok = (rd[7:0] >= 8'h35) && (rd[7:0] <= 8'h37);
    chk({31'h0, ok}, 32'h1, "gate high");
    wr(CTL0, 32'h08);
    wr(CNT0, 32'h03);
    pulse(2);
    rdc(CNT0, 32'h01, "event count");
    pulse(1);
    rdc(CTL0, 32'h88, "event zero");
    wr(CTL0, 32'hC8);
    chk({30'h0, irq}, 32'h1, "irq of timer one");
    chk({31'h0, wake}, 32'h1, "wake of timer one");
    $display("test pin inputs done");

    seed = xs(seed);
    wr(PSC0, {24'h0, seed[7:0] | 8'h80});
    rdc(PSC0, {25'h0, seed[6:0]}, "psc load");
    wr(CTL0, 32'h00);
    rdc(PSC0, 32'h7F, "psc forced");
    wr(PSC0, 32'h11);
    rdc(PSC0, 32'h7F, "psc held");
    $display("test prescaler done");

    wr(CTL0, 32'h38);
    chk({31'h0, pin_oe_n}, 32'h0, "pin driven");
    wr(CNT0, 32'h00);
    chk({31'h0, pin_wire}, 32'h1, "pin high");
    wr(CTL0, 32'h28);
    chk({31'h0, pin_wire}, 32'h1, "pin latched");
    wr(CNT0, 32'h00);
    chk({31'h0, pin_wire}, 32'h0, "pin low");
    wr(CTL0, 32'h00);
    chk({31'h0, pin_oe_n}, 32'h1, "pin released");
    $display("test output mode done");
    conclude;
  end
endmodule
`default_nettype wire

//--- verilog/dpt_pkg.sv
// Constants, field layout and types shared by the dual prescaled down timer
package dpt_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned CNT_W   = 8;
  localparam int unsigned PSC_W   = 7;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned NUM_TMR = 2;

  // ==========================================================================
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PSC [0:1] = '{8'hD2, 8'hD5};
  localparam logic [7:0] IDX_CNT [0:1] = '{8'hD3, 8'hD6};
  localparam logic [7:0] IDX_CTL [0:1] = '{8'hD4, 8'hD7};

  // ==========================================================================
  // Values after reset
  localparam logic [7:0]  CNT_RST   = 8'hFF;
  localparam logic [6:0]  PSC_RST   = 7'h7F;
  localparam logic [7:0]  CTL_RST   = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================================
  // Control field positions
  localparam int unsigned BIT_ZERO = 7;
  localparam int unsigned BIT_IEN  = 6;
  localparam int unsigned BIT_DIR  = 5;
  localparam int unsigned BIT_DOUT = 4;
  localparam int unsigned BIT_RUN  = 3;
  localparam int unsigned TAP_LSB  = 0;

  // ==========================================================================
  // Internal clock divider feeding both prescalers
  localparam int unsigned DIV_INT_CYC = 12;

  typedef struct packed {
    logic       zero_flag;
    logic       zero_irq_enable;
    logic       pin_direction_select;
    logic       pin_data;
    logic       prescaler_run;
    logic [2:0] tap_select;
  } dpt_ctrl_s;

  typedef enum logic [1:0] {
    DPT_MODE_EVENT  = 2'b00,
    DPT_MODE_GATED  = 2'b01,
    DPT_MODE_OUT_LO = 2'b10,
    DPT_MODE_OUT_HI = 2'b11
  } dpt_mode_e;

endpackage

//--- verilog/dpt_sync2.sv
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module dpt_sync2 (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Level
  input  wire logic d_i,
  output var  logic q_o
);
  logic meta;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

//--- verilog/dpt_tick_div.sv
// Free running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module dpt_tick_div #(
  parameter int unsigned DIV = dpt_pkg::DIV_INT_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Tick
  output logic      tick_o
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;

  assign tick_o = (cnt == LAST);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (tick_o) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
endmodule
`default_nettype wire

//--- verilog/dpt_timer.sv
// Dual prescaled down timer with APB register access and one timer pin
//
// Summary of operation
// - Each timer is an 8-bit down counter behind a 7-bit prescaler.
// - Counter drops by one per selected tap rising edge; software loads and reads it.
// - Reaching zero sets the zero flag; with enable set an interrupt is requested.
// - An enabled timer request also serves as a wake-up event.
// - Prescaler counts internal clock over twelve; timer one may use its pin.
// - Tap zero uses prescaler input; higher taps use prescaler bit tap minus one.
// - Run bit low forces prescaler to all ones and stops the counter.
// - With run bit high, software may load any prescaler value up to 7Fh.
// - Timer one mode from direction and data bits: event, gated, drive low, high.
// - Gated mode counts the divided clock only while the pin is high.
// - Event mode counts each rising edge of the pin.
// - Output mode latches pin data onto the pin at each zero flag rise.
// - Timer two always uses the divided clock and has no pin.
// - Zero flag also sets on writing zero count or writing control bit seven.
// - Reset gives count FFh, prescaler 7Fh and a cleared control register.
// - A count write beats a simultaneous decrement to zero; the decrement does not set the flag.
// - Count and prescaler reads return the values held in the setup cycle, at any time.
// - Tap select code n divides by two to the power n.
// - Prescaler reads return zero in bit seven.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dpt_timer (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [dpt_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [dpt_pkg::DATA_W-1:0] pwdata_i,
  output var  logic [dpt_pkg::DATA_W-1:0] prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // Timer pin of the first timer
  input  wire logic                   tmr_pin_i,
  output var  logic                   tmr_pin_o,
  output logic                        tmr_pin_oe_n_o,
  // Requests
  output logic [1:0]                  zero_irq_o,
  output logic                        wake_o
);
  import dpt_pkg::*;

  // ==========================================================================
  // Bus decode
  logic                setup;
  logic                wr;
  logic                in_range;
  logic [7:0]          word_idx;
  logic [NUM_TMR-1:0]  hit_psc;
  logic [NUM_TMR-1:0]  hit_cnt;
  logic [NUM_TMR-1:0]  hit_ctl;
  logic                mapped;
  logic [DATA_W-1:0]   next_rdata;

  assign setup     = psel_i & ~penable_i;
  assign wr        = psel_i & penable_i & pwrite_i;
  assign in_range  = (paddr_i[1:0] == 2'b00) & (paddr_i[ADDR_W-1:10] == '0);
  assign word_idx  = paddr_i[9:2];
  assign mapped    = |{hit_psc, hit_cnt, hit_ctl};
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // ==========================================================================
  // Timer state
  dpt_ctrl_s          ctrl [NUM_TMR];
  logic [CNT_W-1:0]   cnt  [NUM_TMR];
  logic [PSC_W-1:0]   prescale_state  [NUM_TMR];
  logic [NUM_TMR-1:0] tick_in;
  logic [NUM_TMR-1:0] cnt_tick;
  logic [NUM_TMR-1:0] psc_wr;
  logic [NUM_TMR-1:0] cnt_wr;
  logic [NUM_TMR-1:0] ctl_wr;
  logic [NUM_TMR-1:0] dec_zero;
  logic [NUM_TMR-1:0] zero_set;

  // ==========================================================================
  // Shared divided clock and pin input
  logic      div_tick;
  logic      pin_s;
  logic      pin_d;
  logic      pin_rise;
  logic      flag0_d;
  dpt_mode_e mode0;

  dpt_tick_div #(
    .DIV(DIV_INT_CYC)
  ) u_div (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .tick_o (div_tick)
  );

  // Pin comes from off chip, so it is resynchronised before any use
  dpt_sync2 u_pin_sync (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .d_i    (tmr_pin_i),
    .q_o    (pin_s)
  );

  assign pin_rise = pin_s & ~pin_d;
  assign mode0    = dpt_mode_e'({ctrl[0].pin_direction_select, ctrl[0].pin_data});

  // ==========================================================================
  // Per-timer datapath
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    logic [PSC_W-1:0] psc_dec;
    logic [2:0]       tap;
    logic [2:0]       tap_m1;
    logic             tap_rise;
    logic             run;
    logic             next_flag;

    assign hit_psc[i] = in_range & (word_idx == IDX_PSC[i]);
    assign hit_cnt[i] = in_range & (word_idx == IDX_CNT[i]);
    assign hit_ctl[i] = in_range & (word_idx == IDX_CTL[i]);
    assign psc_wr[i]  = wr & hit_psc[i];
    assign cnt_wr[i]  = wr & hit_cnt[i];
    assign ctl_wr[i]  = wr & hit_ctl[i];

    if (i == 0) begin : g_pin
      // Event counts pin edges, gated qualifies the divided clock by the pin
      assign tick_in[i] = (mode0 == DPT_MODE_EVENT) ? pin_rise :
                          (mode0 == DPT_MODE_GATED) ? (div_tick & pin_s) :
                          div_tick;
    end else begin : g_nopin
      assign tick_in[i] = div_tick;
    end

    assign run      = ctrl[i].prescaler_run;
    assign psc_dec  = prescale_state[i] - 7'h01;
    assign tap      = ctrl[i].tap_select;
    assign tap_m1   = tap - 3'd1;
    // A down counter bit rises exactly when it goes from 0 to 1 on a step
    assign tap_rise = (tap == 3'd0) ? 1'b1 :
                      (~prescale_state[i][tap_m1] & psc_dec[tap_m1]);
    assign cnt_tick[i] = run & tick_in[i] & tap_rise;
    // The write path wins over a decrement landing on zero
    assign dec_zero[i] = cnt_tick[i] & (cnt[i] == 8'h01) & ~cnt_wr[i];
    assign zero_set[i] = dec_zero[i] |
                         (cnt_wr[i] & (pwdata_i[CNT_W-1:0] == 8'h00)) |
                         (ctl_wr[i] & pwdata_i[BIT_ZERO]);
    // Hardware set beats a software clear in the same cycle
    assign next_flag = (ctl_wr[i] ? pwdata_i[BIT_ZERO] : ctrl[i].zero_flag) | zero_set[i];

    assign zero_irq_o[i] = ctrl[i].zero_flag & ctrl[i].zero_irq_enable;

    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        prescale_state[i]  <= PSC_RST;
        cnt[i]  <= CNT_RST;
        ctrl[i] <= dpt_ctrl_s'(CTL_RST);
      end else begin
        if (!run) begin
          prescale_state[i] <= PSC_RST;
        end else if (psc_wr[i]) begin
          prescale_state[i] <= pwdata_i[PSC_W-1:0];
        end else if (tick_in[i]) begin
          prescale_state[i] <= psc_dec;
        end
        if (cnt_wr[i]) begin
          cnt[i] <= pwdata_i[CNT_W-1:0];
        end else if (cnt_tick[i]) begin
          cnt[i] <= cnt[i] - 8'h01;
        end
        ctrl[i].zero_flag <= next_flag;
        if (ctl_wr[i]) begin
          ctrl[i].zero_irq_enable      <= pwdata_i[BIT_IEN];
          ctrl[i].pin_direction_select <= pwdata_i[BIT_DIR];
          ctrl[i].pin_data             <= pwdata_i[BIT_DOUT];
          ctrl[i].prescaler_run        <= pwdata_i[BIT_RUN];
          ctrl[i].tap_select           <= pwdata_i[TAP_LSB+2:TAP_LSB];
        end
      end
    end
  end

  assign wake_o = |zero_irq_o;

  // ==========================================================================
  // Pin output; the latch holds its value until the next zero flag rise
  assign tmr_pin_oe_n_o = ~ctrl[0].pin_direction_select;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_d     <= 1'b0;
      flag0_d   <= 1'b0;
      tmr_pin_o <= 1'b0;
    end else begin
      pin_d   <= pin_s;
      flag0_d <= ctrl[0].zero_flag;
      if (ctrl[0].zero_flag & ~flag0_d) begin
        tmr_pin_o <= ctrl[0].pin_data;
      end
    end
  end

  // ==========================================================================
  // Read data is captured in the setup cycle so prdata_o comes from a flop
  assign next_rdata = hit_psc[0] ? {25'h0, prescale_state[0]} :
                      hit_cnt[0] ? {24'h0, cnt[0]} :
                      hit_ctl[0] ? {24'h0, ctrl[0]} :
                      hit_psc[1] ? {25'h0, prescale_state[1]} :
                      hit_cnt[1] ? {24'h0, cnt[1]} :
                      hit_ctl[1] ? {24'h0, ctrl[1]} :
                      RDATA_RST;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_o <= RDATA_RST;
    end else if (setup) begin
      prdata_o <= next_rdata;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_loads_values: assert property (
    disable iff (1'b0)
    !rst_n_i |=> (cnt[0] == 8'hFF) && (prescale_state[0] == 7'h7F) && (ctrl[1] == 8'h00))
    else $error("reset values wrong");

  a_stop_holds_timer: assert property (
    (!ctrl[0].prescaler_run && !cnt_wr[0]) |=> (prescale_state[0] == 7'h7F) && $stable(cnt[0]))
    else $error("stopped timer moved");

  a_dec_sets_flag: assert property (
    (cnt_tick[0] && (cnt[0] == 8'h01) && !cnt_wr[0]) |=> ctrl[0].zero_flag && (cnt[0] == 8'h00))
    else $error("zero reach did not set flag");

  a_write_beats_dec: assert property (
    (cnt_wr[0] && (pwdata_i[7:0] != 8'h00) && !ctrl[0].zero_flag && !ctl_wr[0])
    |=> !ctrl[0].zero_flag && (cnt[0] == $past(pwdata_i[7:0])))
    else $error("count write lost or flag set");

  a_zero_write_flag: assert property (
    (cnt_wr[1] && (pwdata_i[7:0] == 8'h00)) |=> ctrl[1].zero_flag)
    else $error("zero write did not set flag");

  a_tap_one_step: assert property (
    (ctrl[1].prescaler_run && (ctrl[1].tap_select == 3'd0) && div_tick && !cnt_wr[1])
    |=> cnt[1] == $past(cnt[1]) - 8'h01)
    else $error("divide by one did not step");

  a_gated_pin_low: assert property (
    ((mode0 == DPT_MODE_GATED) && ctrl[0].prescaler_run && !pin_s && !psc_wr[0])
    |=> $stable(prescale_state[0]))
    else $error("gated prescaler ran with pin low");

  a_timer2_div_only: assert property (
    (ctrl[1].prescaler_run && !div_tick && !psc_wr[1]) |=> $stable(prescale_state[1]))
    else $error("second prescaler moved off tick");

  a_pin_latch_zero: assert property (
    $rose(ctrl[0].zero_flag) |=> tmr_pin_o == $past(ctrl[0].pin_data))
    else $error("pin did not take data bit");

  a_psc_read_top: assert property (
    (setup && hit_psc[0]) |=> prdata_o == {25'h0, $past(prescale_state[0])})
    else $error("prescaler read wrong");

  a_irq_wakes: assert property (
    (ctrl[1].zero_flag && ctrl[1].zero_irq_enable) |-> zero_irq_o[1] && wake_o)
    else $error("enabled request missing");

  a_reset_pin_idle: assert property (
    disable iff (1'b0)
    !rst_n_i |=> !tmr_pin_o && tmr_pin_oe_n_o && (zero_irq_o == 2'b00)
    && (prdata_o == RDATA_RST))
    else $error("pin or requests not idle after reset");

  a_reset_second_tmr: assert property (
    disable iff (1'b0)
    !rst_n_i |=> (cnt[1] == CNT_RST) && (prescale_state[1] == PSC_RST) && (ctrl[0] == CTL_RST))
    else $error("second timer reset values wrong");

  a_psc_steps_tick: assert property (
    (ctrl[0].prescaler_run && tick_in[0] && !psc_wr[0]) |=> prescale_state[0] == $past(prescale_state[0]) - 7'h01)
    else $error("prescaler missed its input tick");

  a_psc_write_lands: assert property (
    (psc_wr[0] && ctrl[0].prescaler_run) |=> prescale_state[0] == $past(pwdata_i[PSC_W-1:0]))
    else $error("prescaler write lost");

  a_event_no_div: assert property (
    ((mode0 == DPT_MODE_EVENT) && ctrl[0].prescaler_run && !pin_rise && !psc_wr[0])
    |=> $stable(prescale_state[0]))
    else $error("event prescaler moved without pin edge");

  a_gated_pin_high: assert property (
    ((mode0 == DPT_MODE_GATED) && ctrl[0].prescaler_run && pin_s && div_tick && !psc_wr[0])
    |=> prescale_state[0] == $past(prescale_state[0]) - 7'h01)
    else $error("gated prescaler missed a tick");

  a_out_mode_div: assert property (
    (ctrl[0].pin_direction_select && ctrl[0].prescaler_run && !div_tick && !psc_wr[0])
    |=> $stable(prescale_state[0]))
    else $error("output mode prescaler moved off tick");

  a_pin_holds: assert property (
    !$rose(ctrl[0].zero_flag) |=> $stable(tmr_pin_o))
    else $error("pin changed without zero flag rise");

  a_cnt_holds: assert property (
    (!cnt_tick[1] && !cnt_wr[1]) |=> $stable(cnt[1]))
    else $error("count moved without tap edge");

  a_cnt_read_now: assert property (
    (setup && hit_cnt[1]) |=> prdata_o == {24'h0, $past(cnt[1])})
    else $error("count read not current");

  a_ctl_read_now: assert property (
    (setup && hit_ctl[0]) |=> prdata_o == {24'h0, $past(ctrl[0])})
    else $error("control read not current");

  a_flag_sw_clear: assert property (
    (ctl_wr[1] && !pwdata_i[BIT_ZERO] && !dec_zero[1]) |=> !ctrl[1].zero_flag)
    else $error("software clear of flag lost");

  a_wake_timer0: assert property (
    (ctrl[0].zero_flag && ctrl[0].zero_irq_enable) |-> zero_irq_o[0] && wake_o)
    else $error("first timer request missing");

  a_irq_quiet: assert property (
    (!(ctrl[0].zero_flag && ctrl[0].zero_irq_enable)
     && !(ctrl[1].zero_flag && ctrl[1].zero_irq_enable)) |-> !wake_o)
    else $error("wake without enabled request");

  a_tap_rise_step: assert property (
    (ctrl[1].prescaler_run && (ctrl[1].tap_select == 3'd1) && div_tick && !prescale_state[1][0]
     && !cnt_wr[1] && !psc_wr[1]) |=> cnt[1] == $past(cnt[1]) - 8'h01)
    else $error("tap bit rise did not step count");

  a_tap_fall_hold: assert property (
    (ctrl[1].prescaler_run && (ctrl[1].tap_select == 3'd1) && prescale_state[1][0]
     && !cnt_wr[1] && !psc_wr[1]) |=> $stable(cnt[1]))
    else $error("count stepped without tap bit rise");

endmodule
`default_nettype wire
